// [pump_ttl_io_control.sv]
// Pump logic I/O port: input filter, edge detect, trigger and direction control, outputs.
// Assumes pins synchronous to aclk and an AXI4-Lite master on the register side.
`timescale 1ns/1ps
`include "pump_ttl_defines.svh"

module pump_ttl_io_control
    import pump_ttl_pkg::*;
#(
    parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
    parameter int STABLE_SAMPLES = `STABLE_SAMPLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic trig_in,
    input wire logic dir_in,
    input wire logic event_in,
    input wire logic prog_in,
    input wire logic editing,
    input wire logic alarm,
    input wire logic motor_active,
    input wire logic pause_active,
    input wire logic run_done,
    input wire logic prog_set_valid,
    input wire logic prog_set_level,
    output logic run_req_ff,
    output logic motor_out_ff,
    output logic dir_out_ff,
    output logic prog_out_ff,
    output logic prog_level_ff,
    output logic event_level_ff,
    output logic event_rise_ff,
    output logic event_fall_ff
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Returns {start, stop} for a trigger edge
    function automatic logic [1:0] trig_action(trig_mode_type m, logic rise, logic fall, logic run);
        logic [1:0] a;
        a = 2'h0;
        case (m)
            foot_toggle: a = fall ? {!run, run} : 2'h0;
            foot_toggle_inverted: a = rise ? {!run, run} : 2'h0;
            foot_hold_run: a = {fall, rise};
            gated_run_mode: a = {rise, fall};
            begin_only_mode: a = {fall, 1'b0};
            begin_only_inverted: a = {rise, 1'b0};
            halt_only_mode: a = {1'b0, fall};
            halt_only_inverted: a = {1'b0, rise};
            default: a = 2'h0;
        endcase
        return a;
    endfunction

    // Sample tick
    logic [31:0] tick_cnt_ff;
    wire tick = (tick_cnt_ff == 32'(SAMPLE_CYCLES - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) tick_cnt_ff <= 32'h0;
        else tick_cnt_ff <= tick_cnt_ff + 32'h1;
    end

    // Input filter
    wire [`NUM_INPUTS-1:0] raw = {prog_in, event_in, dir_in, trig_in};
    logic [`NUM_INPUTS-1:0] cand_ff, filt_ff, seen_ff, rise_ff, fall_ff;
    logic [`NUM_INPUTS-1:0] nxt_cand, nxt_filt, nxt_seen, nxt_rise, nxt_fall;
    logic [2:0] cnt_ff [`NUM_INPUTS];
    logic [2:0] nxt_cnt [`NUM_INPUTS];

    always_comb begin
        for (int i = 0; i < `NUM_INPUTS; i++) begin
            nxt_cand[i] = cand_ff[i];
            nxt_cnt[i] = cnt_ff[i];
            nxt_filt[i] = filt_ff[i];
            nxt_seen[i] = seen_ff[i];
            nxt_rise[i] = 1'b0;
            nxt_fall[i] = 1'b0;
            if (tick) begin
                if (raw[i] != cand_ff[i]) begin
                    nxt_cand[i] = raw[i];
                    nxt_cnt[i] = 3'h1;
                end else if (cnt_ff[i] < 3'(STABLE_SAMPLES)) begin
                    nxt_cnt[i] = cnt_ff[i] + 3'h1;
                end
                if (nxt_cnt[i] >= 3'(STABLE_SAMPLES) && (nxt_cand[i] != filt_ff[i] || !seen_ff[i])) begin
                    nxt_filt[i] = nxt_cand[i];
                    nxt_seen[i] = 1'b1;
                    nxt_rise[i] = seen_ff[i] && nxt_cand[i];
                    nxt_fall[i] = seen_ff[i] && !nxt_cand[i];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cand_ff <= '0;
            filt_ff <= '0;
            seen_ff <= '0;
            rise_ff <= '0;
            fall_ff <= '0;
            for (int i = 0; i < `NUM_INPUTS; i++) cnt_ff[i] <= 3'h0;
        end else begin
            cand_ff <= nxt_cand;
            filt_ff <= nxt_filt;
            seen_ff <= nxt_seen;
            rise_ff <= nxt_rise;
            fall_ff <= nxt_fall;
            for (int i = 0; i < `NUM_INPUTS; i++) cnt_ff[i] <= nxt_cnt[i];
        end
    end

    // Register bus write side
    logic aw_held_ff, w_held_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic wstrb0_ff;
    trig_mode_type trig_mode_ff;
    dir_mode_type dir_mode_ff;
    logic mop_ff;
    wire wr_go = aw_held_ff && w_held_ff && !bvalid;
    wire nxt_aw_held = (aw_held_ff && !wr_go) || (awvalid && awready);
    wire nxt_w_held = (w_held_ff && !wr_go) || (wvalid && wready);
    wire wr_hit = awaddr_ff == `CTRL_OFFSET || awaddr_ff == `DIR_OFFSET || awaddr_ff == `STATUS_OFFSET;
    wire wr_ctrl = wr_go && wstrb0_ff && awaddr_ff == `CTRL_OFFSET;
    wire wr_dir = wr_go && wstrb0_ff && awaddr_ff == `DIR_OFFSET;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            awaddr_ff <= 8'h0;
            wdata_ff <= 32'h0;
            wstrb0_ff <= 1'b0;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awready <= !nxt_aw_held;
            wready <= !nxt_w_held;
            if (awvalid && awready) awaddr_ff <= awaddr;
            if (wvalid && wready) begin
                wdata_ff <= wdata;
                wstrb0_ff <= wstrb[0];
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Register bus read side
    wire [31:0] ctrl_word = {26'h0, prog_out_ff, mop_ff, dir_mode_ff, trig_mode_ff};
    wire [31:0] dir_word = {31'h0, dir_out_ff};
    wire [31:0] status_word = {25'h0, &seen_ff, dir_out_ff, run_req_ff, filt_ff};
    wire rd_ctrl = araddr == `CTRL_OFFSET;
    wire rd_dir = araddr == `DIR_OFFSET;
    wire rd_status = araddr == `STATUS_OFFSET;
    wire [31:0] rd_word = rd_ctrl ? ctrl_word : rd_dir ? dir_word : rd_status ? status_word : 32'h0;
    wire ar_take = arvalid && arready;
    wire nxt_rvalid = ar_take || (rvalid && !rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `RESP_OKAY;
        end else begin
            arready <= !nxt_rvalid;
            rvalid <= nxt_rvalid;
            if (ar_take) begin
                rdata <= rd_word;
                rresp <= (rd_ctrl || rd_dir || rd_status) ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // Trigger, direction and output logic
    wire lock = editing || alarm;
    wire [1:0] act = trig_action(trig_mode_ff, rise_ff[`IN_TRIG], fall_ff[`IN_TRIG], run_req_ff);
    wire alt = dir_mode_ff == alternating_direction_mode;
    wire to_disp = alt ? fall_ff[`IN_DIR] : rise_ff[`IN_DIR];
    wire to_wd = alt ? rise_ff[`IN_DIR] : fall_ff[`IN_DIR];
    logic nxt_run, nxt_disp;

    always_comb begin
        nxt_run = run_done ? 1'b0 : run_req_ff;
        if (!lock && act[1]) nxt_run = 1'b1;
        else if (!lock && act[0]) nxt_run = 1'b0;
        nxt_disp = dir_out_ff;
        if (wr_dir) nxt_disp = wdata_ff[0];
        else if (!lock && to_disp && !dir_out_ff) nxt_disp = 1'b1;
        else if (!lock && to_wd && dir_out_ff) nxt_disp = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_mode_ff <= foot_toggle;
            dir_mode_ff <= alternating_direction_mode;
            mop_ff <= 1'b0;
            run_req_ff <= 1'b0;
            motor_out_ff <= 1'b0;
            dir_out_ff <= 1'b0;
            prog_out_ff <= 1'b0;
            prog_level_ff <= 1'b0;
            event_level_ff <= 1'b0;
            event_rise_ff <= 1'b0;
            event_fall_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                trig_mode_ff <= trig_mode_type'(wdata_ff[`CTRL_TRIG_MSB:`CTRL_TRIG_LSB]);
                dir_mode_ff <= dir_mode_type'(wdata_ff[`CTRL_DIRMODE_BIT]);
                mop_ff <= wdata_ff[`CTRL_MOP_BIT];
            end
            if (prog_set_valid) prog_out_ff <= prog_set_level;
            else if (wr_ctrl) prog_out_ff <= wdata_ff[`CTRL_PROGOUT_BIT];
            run_req_ff <= nxt_run;
            dir_out_ff <= nxt_disp;
            motor_out_ff <= motor_active || (mop_ff && pause_active);
            prog_level_ff <= filt_ff[`IN_PROG];
            event_level_ff <= filt_ff[`IN_EVENT];
            event_rise_ff <= rise_ff[`IN_EVENT];
            event_fall_ff <= fall_ff[`IN_EVENT];
        end
    end

    sequence s_trig_fall_free;
        fall_ff[`IN_TRIG] && !lock && !run_done;
    endsequence

    a_accept_after_stable: assert property ($past(aresetn) && $changed(filt_ff) |->
        $past(tick) && cnt_ff[`IN_TRIG] >= 3'(STABLE_SAMPLES) || $changed(filt_ff[3:1]))
        else $error("filtered level accepted before stable");
    a_sample_on_tick: assert property (!$past(tick) && $past(aresetn) |-> $stable(filt_ff))
        else $error("filtered level changed off tick");
    a_rise_is_change: assert property (|rise_ff |-> (rise_ff & ~filt_ff) == '0
        && (rise_ff & $past(filt_ff)) == '0) else $error("rising edge without low to high");
    a_fall_is_change: assert property (|fall_ff |-> (fall_ff & filt_ff) == '0)
        else $error("falling edge without high to low");
    a_toggle_flips: assert property (trig_mode_ff == foot_toggle and s_trig_fall_free |=>
        run_req_ff != $past(run_req_ff)) else $error("toggle did not flip run");
    a_begin_only_keeps: assert property (trig_mode_ff == begin_only_mode && run_req_ff && !run_done
        |=> run_req_ff) else $error("begin-only mode stopped the run");
    a_alt_dispense: assert property (alt && fall_ff[`IN_DIR] && !lock && !wr_dir |=> dir_out_ff)
        else $error("alternating fall did not select dispense");
    a_motor_output: assert property (##1 motor_out_ff == $past(motor_active || (mop_ff && pause_active)))
        else $error("motor output wrong");
    a_lock_holds: assert property (lock && !run_done && !wr_dir |=> $stable(run_req_ff) && $stable(dir_out_ff))
        else $error("edge acted under lock");
    a_first_no_edge: assert property (seen_ff == '0 |=> rise_ff == '0 && fall_ff == '0)
        else $error("edge on first accepted level");

    // Direction, trigger, event, filter count and program input and output checks
    sequence s_dir_edge_free;
        !lock && !wr_dir;
    endsequence

    a_paired_withdraw: assert property (!alt && fall_ff[`IN_DIR] and s_dir_edge_free |=> !dir_out_ff)
        else $error("paired fall did not select withdraw");
    a_disp_stays_put: assert property (to_disp && dir_out_ff && !wr_dir |=> dir_out_ff)
        else $error("dispense edge changed dispense direction");
    a_wd_stays_put: assert property (to_wd && !dir_out_ff && !wr_dir |=> !dir_out_ff)
        else $error("withdraw edge changed withdraw direction");
    a_dir_sw_write: assert property (wr_dir |=> dir_out_ff == $past(wdata_ff[0]))
        else $error("direction write not applied");
    a_hold_starts: assert property (trig_mode_ff == foot_hold_run and s_trig_fall_free |=> run_req_ff)
        else $error("hold mode fall did not start");
    a_gated_stops: assert property (trig_mode_ff == gated_run_mode and s_trig_fall_free |=> !run_req_ff)
        else $error("gated mode fall did not stop");
    a_halt_only_idle: assert property ((trig_mode_ff == halt_only_mode || trig_mode_ff == halt_only_inverted)
        && !run_req_ff |=> !run_req_ff) else $error("halt-only mode started the run");
    a_event_level_up: assert property (event_rise_ff |-> event_level_ff)
        else $error("event rise without high level");
    a_event_level_down: assert property (event_fall_ff |-> !event_level_ff)
        else $error("event fall without low level");
    a_prog_level: assert property (##1 prog_level_ff == $past(filt_ff[`IN_PROG]))
        else $error("program input level not passed on");
    a_restart_count: assert property (tick && raw[`IN_EVENT] != cand_ff[`IN_EVENT] |=> cnt_ff[`IN_EVENT] == 3'h1)
        else $error("stability count not restarted");
    a_prog_command: assert property (prog_set_valid |=> prog_out_ff == $past(prog_set_level))
        else $error("program output command not applied");
endmodule // pump_ttl_io_control

// [pump_ttl_defines.svh]
// Constants for the pump logic I/O port: timing, register map, field positions.
// Assumes a 100 MHz aclk and an AXI4-Lite master with 32-bit data.
// What this block does
// - A control input level is accepted only after it has read the same on two consecutive samples, 50 ms apart.
// - Each control input is sampled every 50 ms and pulses shorter than 50 ms are dropped as glitches.
// - An edge is reported only when the filtered level differs from the previously accepted level.
// - Edges can follow at up to 10 Hz, the opposite level being accepted 100 ms after an edge.
// - High to low on a filtered input is a falling edge, low to high a rising edge.
// - The trigger follows its mode: toggle on falling, toggle on rising, hold-to-run, or gated run.
// - Begin-only modes can only start and halt-only modes can only stop, on falling or rising edges.
// - Alternating mode maps falling to dispense and rising to withdraw; paired mode the reverse.
// - Motor output is high while pumping, and also during a pause timer when motor-or-pause is set.
// - Direction output is high for dispense and low for withdraw.
// - The filtered conditional input level is offered to the program, lockout logic and software.
// - The program output is set by the program or software, and the event input gives edges and a level.
// - Trigger and direction edges are ignored while settings are edited or an alarm is present.
// - A direction edge acts only if it moves the direction away from its current value.
`ifndef PUMP_TTL_DEFINES_SVH
`define PUMP_TTL_DEFINES_SVH

`define CLK_PERIOD_NS 10
`define NS_PER_MS 1000000
`define SAMPLE_PERIOD_MS 50
`define STABLE_TIME_MS 100
`define SAMPLE_CYCLES (`SAMPLE_PERIOD_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define STABLE_SAMPLES ((`STABLE_TIME_MS + `SAMPLE_PERIOD_MS - 1) / `SAMPLE_PERIOD_MS)

`define NUM_INPUTS 4
`define IN_TRIG 0
`define IN_DIR 1
`define IN_EVENT 2
`define IN_PROG 3

`define CTRL_OFFSET 8'h00
`define DIR_OFFSET 8'h04
`define STATUS_OFFSET 8'h08

`define CTRL_TRIG_LSB 0
`define CTRL_TRIG_MSB 2
`define CTRL_DIRMODE_BIT 3
`define CTRL_MOP_BIT 4
`define CTRL_PROGOUT_BIT 5

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [pump_ttl_pkg.sv]
// Types for the pump logic I/O port.
// Assumes nothing beyond the defines header.
package pump_ttl_pkg;
    typedef enum logic [2:0] {
        foot_toggle,
        foot_hold_run,
        foot_toggle_inverted,
        gated_run_mode,
        begin_only_mode,
        begin_only_inverted,
        halt_only_mode,
        halt_only_inverted
    } trig_mode_type;

    typedef enum logic {
        alternating_direction_mode,
        paired_direction_mode
    } dir_mode_type;
endpackage

// [ext_equipment.sv]
// Far-side model: switches or a timer driving the four control pins.
// Assumes calls start just after a rising aclk edge.
`timescale 1ns/1ps
`include "pump_ttl_defines.svh"
module ext_equipment (
    input wire logic aclk,
    output logic trig_in,
    output logic dir_in,
    output logic event_in,
    output logic prog_in
);
    initial begin
        trig_in = 1'b1;
        dir_in = 1'b1;
        event_in = 1'b0;
        prog_in = 1'b0;
    end

    // Change one pin, then hold it; trigger and direction use holds over one tick
    task automatic drive(input int idx, input logic v, input int hold);
        @(posedge aclk);
        case (idx)
            `IN_TRIG: trig_in <= v;
            `IN_DIR: dir_in <= v;
            `IN_EVENT: event_in <= v;
            default: prog_in <= v;
        endcase
        repeat (hold) @(posedge aclk);
    endtask

    // Event pulse shorter than one tick
    task automatic glitch();
        @(posedge aclk);
        event_in <= 1'b1;
        repeat (4) @(posedge aclk);
        event_in <= 1'b0;
        repeat (40) @(posedge aclk);
    endtask
endmodule // ext_equipment

// [pump_ttl_io_control_tb_top.sv]
// Self-checking bench for the pump logic I/O port.
// Assumes a short sample tick of 8 cycles and two stable samples.
`timescale 1ns/1ps
`include "pump_ttl_defines.svh"
module pump_ttl_io_control_tb_top
    import pump_ttl_pkg::*;
;
    localparam logic [7:0] init_set = 8'hcc;
    localparam logic [7:0] fall_exp = 8'h97;
    localparam logic [7:0] rise_exp = 8'h39;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd;
    logic [3:0] wstrb = 0;
    logic editing = 0, alarm = 0, motor_active = 0, pause_active = 0;
    logic run_done = 0, prog_set_valid = 0, prog_set_level = 0;
    logic [1:0] rs, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, run_req_ff, motor_out_ff, dir_out_ff;
    logic prog_out_ff, prog_level_ff, event_level_ff, event_rise_ff, event_fall_ff;
    logic trig_in, dir_in, event_in, prog_in;
    logic [31:0] rdata;
    int miscompares = 0, checks_done = 0, rises = 0, falls = 0;

    pump_ttl_io_control #(.SAMPLE_CYCLES(8), .STABLE_SAMPLES(2)) dut_u (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .trig_in, .dir_in, .event_in, .prog_in, .editing, .alarm, .motor_active, .pause_active,
        .run_done, .prog_set_valid, .prog_set_level, .run_req_ff, .motor_out_ff, .dir_out_ff,
        .prog_out_ff, .prog_level_ff, .event_level_ff, .event_rise_ff, .event_fall_ff);
    ext_equipment u_ext (.aclk, .trig_in, .dir_in, .event_in, .prog_in);

    initial begin
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (event_rise_ff === 1'b1) rises++;
        if (event_fall_ff === 1'b1) falls++;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task axi_read(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task set_ctrl(input logic [2:0] m, input logic dm, input logic mop, input logic pg);
        axi_write(`CTRL_OFFSET, {26'h0, pg, mop, dm, m});
    endtask
    task t_reset_regs;
        check({run_req_ff, motor_out_ff, dir_out_ff, prog_out_ff}, 0);
        repeat (40) @(posedge aclk);
        axi_read(`STATUS_OFFSET);
        check(rd, 32'h43);
        axi_read(`CTRL_OFFSET);
        check(rd, 0);
        set_ctrl(begin_only_inverted, paired_direction_mode, 1, 0);
        axi_read(`CTRL_OFFSET);
        check(rd, 32'h1d);
        axi_read(8'h0c);
        check(rs, `RESP_SLVERR);
        check(rd, 0);
        axi_write(8'h10, 1);
        check(rs, `RESP_SLVERR);
    endtask
    task t_motor;
        for (int p = 0; p < 8; p++) begin
            if (p % 4 == 0) set_ctrl(foot_toggle, 0, p[2], 0);
            @(posedge aclk);
            motor_active <= p[0];
            pause_active <= p[1];
            repeat (3) @(posedge aclk);
            check(motor_out_ff, p[0] | (p[2] & p[1]));
        end
        motor_active <= 0;
        pause_active <= 0;
    endtask
    task t_event_prog;
        u_ext.glitch();
        check({event_level_ff, rises[3:0]}, 0);
        u_ext.drive(`IN_EVENT, 1, 6);
        check(event_level_ff, 0);
        repeat (16) @(posedge aclk);
        check({event_level_ff, rises[3:0], falls[3:0]}, 9'h110);
        u_ext.drive(`IN_EVENT, 0, 40);
        check({event_level_ff, rises[3:0], falls[3:0]}, 9'h011);
        u_ext.drive(`IN_PROG, 1, 40);
        check(prog_level_ff, 1);
        axi_read(`STATUS_OFFSET);
        check(rd[3:0], 4'hb);
        set_ctrl(foot_toggle, 0, 0, 1);
        repeat (2) @(posedge aclk);
        check(prog_out_ff, 1);
        prog_set_valid <= 1;
        @(posedge aclk);
        prog_set_valid <= 0;
        repeat (2) @(posedge aclk);
        check(prog_out_ff, 0);
        prog_set_level <= 1;
        prog_set_valid <= 1;
        @(posedge aclk);
        prog_set_valid <= 0;
        repeat (2) @(posedge aclk);
        check(prog_out_ff, 1);
    endtask
    task t_lock;
        editing <= 1;
        u_ext.drive(`IN_TRIG, 0, 40);
        check(run_req_ff, 0);
        u_ext.drive(`IN_TRIG, 1, 40);
        editing <= 0;
        alarm <= 1;
        u_ext.drive(`IN_DIR, 0, 40);
        check(dir_out_ff, 0);
        u_ext.drive(`IN_TRIG, 0, 40);
        check(run_req_ff, 0);
        u_ext.drive(`IN_TRIG, 1, 40);
        u_ext.drive(`IN_DIR, 1, 40);
        alarm <= 0;
    endtask
    task t_trigger;
        for (int i = 0; i < 8; i++) begin
            run_done <= 1;
            @(posedge aclk);
            run_done <= 0;
            repeat (2) @(posedge aclk);
            check(run_req_ff, 0);
            if (init_set[i]) set_ctrl(begin_only_mode, 0, 0, 0);
            if (init_set[i]) u_ext.drive(`IN_TRIG, 0, 40);
            if (init_set[i]) u_ext.drive(`IN_TRIG, 1, 40);
            set_ctrl(i[2:0], 0, 0, 0);
            u_ext.drive(`IN_TRIG, 0, 40);
            check(run_req_ff, fall_exp[i]);
            u_ext.drive(`IN_TRIG, 1, 40);
            check(run_req_ff, rise_exp[i]);
        end
    endtask
    task t_direction;
        for (int i = 0; i < 4; i++) begin
            set_ctrl(foot_toggle, i == 1 || i == 2, 0, 0);
            u_ext.drive(`IN_DIR, i[0], 40);
            check(dir_out_ff, i < 2);
        end
        axi_write(`DIR_OFFSET, 1);
        repeat (2) @(posedge aclk);
        check(dir_out_ff, 1);
        axi_read(`STATUS_OFFSET);
        check(rd[5], 1);
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        t_reset_regs;
        t_motor;
        t_event_prog;
        t_lock;
        t_trigger;
        t_direction;
        complete_run;
    end
    initial begin
        repeat (30000) @(posedge aclk);
        miscompares++;
        complete_run;
    end
endmodule // pump_ttl_io_control_tb_top
